// ==== test/alc_link_checker.sv ====
// concurrent checks on the link config bank ports
module alc_link_checker #(
  parameter NCH = 2
) (
  // clock and reset
  input wire logic              clk,
  input wire logic              srst,
  // bus answers
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic [31:0]       s_axi_rdata,
  // data and link side
  input wire logic [NCH*16-1:0] word_out,
  input wire logic              lmfc_reset_req,
  input wire logic              lmfc_reset_out,
  input wire logic [2:0]        link_pattern_select,
  input wire logic              pattern_disparity_flip,
  input wire logic [3:0]        active_lanes,
  input wire logic [2:0]        link_filter_config,
  input wire logic [2:0]        link_lane_mode,
  // digital controls
  input wire logic              digital_core_reset,
  input wire logic [2:0]        nyquist_zone_onehot,
  input wire logic [6:0]        gain_value,
  input wire logic              gain_active
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped or changed before taken");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped or changed before taken");
  a_reset_pulse: assert property ($rose(digital_core_reset) |=> !digital_core_reset)
    else $error("digital reset longer than one cycle");
  a_reset_clears: assert property (digital_core_reset |-> word_out == '0)
    else $error("output word not cleared by digital reset");
  a_gain_gate: assert property (!gain_active |-> gain_value == 7'h00)
    else $error("gain value applied while gain disabled");
  a_zone_onehot: assert property ($onehot0(nyquist_zone_onehot))
    else $error("more than one zone selected");
  a_pattern_code: assert property (link_pattern_select <= 3'h4)
    else $error("unused pattern code passed on");
  a_disp_rpat: assert property (pattern_disparity_flip |-> link_pattern_select == 3'h4)
    else $error("disparity flip outside random pattern mode");
  a_lmfc_cause: assert property (lmfc_reset_out |-> $past(lmfc_reset_req))
    else $error("multiframe clock reset without request");
  a_eight_lanes: assert property ({link_filter_config, link_lane_mode} == 6'h01 |-> active_lanes == 4'h8)
    else $error("bypass default pair not eight lanes");
  a_one_lane: assert property ({link_filter_config, link_lane_mode} == 6'h22 |-> active_lanes == 4'h1)
    else $error("quarter-rate pair not one lane");

  c_digital_core_reset: cover property (digital_core_reset);
  c_disp_flip: cover property (pattern_disparity_flip);
  c_lmfc_out: cover property (lmfc_reset_out);
  c_one_lane: cover property (active_lanes == 4'h1);
endmodule // alc_link_checker

bind alc_link_config alc_link_checker #(.NCH(NCH)) alc_link_checker_inst (
  .clk(clk), .srst(srst), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .word_out(word_out), .lmfc_reset_req(lmfc_reset_req),
  .lmfc_reset_out(lmfc_reset_out), .link_pattern_select(link_pattern_select),
  .pattern_disparity_flip(pattern_disparity_flip), .active_lanes(active_lanes),
  .link_filter_config(link_filter_config), .link_lane_mode(link_lane_mode),
  .digital_core_reset(digital_core_reset), .nyquist_zone_onehot(nyquist_zone_onehot),
  .gain_value(gain_value), .gain_active(gain_active));

// ==== test/alc_rx_model.sv ====
// far-end receiver model: sync request pin and multiframe clock reset requests
module alc_rx_model (
  // clock
  input wire logic clk,
  // link pins
  output logic     sync_req_n_pin,
  output logic     lmfc_reset_req
);
  timeunit 1ns;
  timeprecision 100ps;
  // pin idles high: no request until the receiver asks
  initial begin
    sync_req_n_pin = 1'b1;
    lmfc_reset_req = 1'b0;
  end
  task set_sync(input logic req);
    @(posedge clk);
    sync_req_n_pin <= ~req;
  endtask
  task pulse_lmfc;
    @(posedge clk);
    lmfc_reset_req <= 1'b1;
    @(posedge clk);
    lmfc_reset_req <= 1'b0;
  endtask
endmodule // alc_rx_model

// ==== test/tb_top.sv ====
// testbench for the link config bank: register bus tasks and scenario sequence
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk = 0, srst = 1, ce = 1;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, sync_req_n_pin, lmfc_reset_req, lmfc_reset_out, sync_request;
  logic k28_5_force, ila_send_enable, lane_align_insert, frame_align_insert;
  logic transport_pattern_enable, pattern_disparity_flip, digital_core_reset;
  logic gain_active, lane_remap_active;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, word_out;
  logic [3:0] s_axi_wstrb = 4'hF, active_lanes;
  logic [1:0] s_axi_bresp, s_axi_rresp, fast_overrange_flag = '0;
  logic [27:0] sample_in = '0;
  logic [5:0] frames_per_multiframe;
  logic [2:0] link_pattern_select, link_filter_config, link_lane_mode, nyquist_zone_onehot;
  logic [6:0] gain_value;
  int mismatches = 0, cmp_count = 0, rst_seen = 0, lmfc_seen = 0;
  // lane table entries: {filter, mode, lanes}; last one is an unlisted pair
  logic [9:0] lt [10] = '{10'h044, 10'h024, 10'h018, 10'h394, 10'h314,
                          10'h322, 10'h212, 10'h3A2, 10'h221, 10'h1B0};

  alc_link_config alc_link_config_inst (
    .clk(clk), .srst(srst), .ce(ce), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sample_in(sample_in),
    .fast_overrange_flag(fast_overrange_flag), .word_out(word_out),
    .sync_req_n_pin(sync_req_n_pin), .lmfc_reset_req(lmfc_reset_req),
    .lmfc_reset_out(lmfc_reset_out), .sync_request(sync_request), .k28_5_force(k28_5_force),
    .ila_send_enable(ila_send_enable), .lane_align_insert(lane_align_insert),
    .frame_align_insert(frame_align_insert),
    .transport_pattern_enable(transport_pattern_enable),
    .frames_per_multiframe(frames_per_multiframe), .link_pattern_select(link_pattern_select),
    .pattern_disparity_flip(pattern_disparity_flip), .active_lanes(active_lanes),
    .link_filter_config(link_filter_config), .link_lane_mode(link_lane_mode),
    .digital_core_reset(digital_core_reset), .nyquist_zone_onehot(nyquist_zone_onehot),
    .gain_value(gain_value), .gain_active(gain_active), .lane_remap_active(lane_remap_active));

  alc_rx_model alc_rx_model_inst (.clk(clk), .sync_req_n_pin(sync_req_n_pin),
    .lmfc_reset_req(lmfc_reset_req));

  always #25 clk = ~clk;
  always @(posedge clk) begin
    if (digital_core_reset === 1'b1) rst_seen++;
    if (lmfc_reset_out === 1'b1) lmfc_seen++;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task close_out;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task hang;
    chk("bus answer", 0, 1);
    close_out;
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 0;
        break;
      end
    end
    if (n == 50) hang;
  endtask
  task rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 0;
        break;
      end
    end
    if (n == 50) hang;
  endtask
  // write by register index, then let the control outputs land
  task w(input logic [7:0] i, input logic [7:0] d);
    logic [1:0] r;
    wr({2'b00, i, 2'b00}, d, r);
    @(posedge clk);
    #1;
  endtask
  task rchk(input logic [7:0] i, input logic [31:0] e);
    logic [1:0] r;
    logic [31:0] d;
    rd({2'b00, i, 2'b00}, d, r);
    chk("register read", d, e);
  endtask
  function automatic logic [31:0] wexp(input logic lsb, input logic flip);
    logic [15:0] c;
    logic [31:0] o;
    for (int k = 0; k < 2; k++) begin
      c = {sample_in[k*14+:14], 2'b00};
      if (lsb) c[0] = fast_overrange_flag[k];
      for (int b = 0; b < 16; b++) o[k*16+b] = flip ? c[15-b] : c[b];
    end
    return o;
  endfunction
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    int i, n0;
    logic [1:0] r;
    logic [31:0] d;
    repeat (5) @(posedge clk);
    srst <= 0;
    sample_in <= 28'h2ABCDEF;
    fast_overrange_flag <= 2'b01;
    rchk(8'h01, 32'h01);
    rchk(8'h06, 32'h08);
    chk("frames", frames_per_multiframe, 5);
    chk("lanes", active_lanes, 8);
    chk("lane mode", link_lane_mode, 1);
    chk("ila enable", ila_send_enable, 1);
    w(8'h42, 8'h02);
    chk("zone", nyquist_zone_onehot, 0);
    w(8'h4E, 8'hFF);
    rchk(8'h4E, 32'h80);
    for (i = 0; i < 3; i++) begin
      w(8'h42, i[7:0]);
      chk("zone", nyquist_zone_onehot, 1 << i);
    end
    w(8'h44, 8'h7F);
    chk("gain", gain_value, 0);
    w(8'h52, 8'h01);
    chk("gain", gain_value, 8'h7F);
    chk("gain on", gain_active, 1);
    w(8'h52, 8'h81);
    chk("remap", lane_remap_active, 0);
    w(8'h72, 8'h08);
    chk("remap", lane_remap_active, 1);
    w(8'h52, 8'h01);
    w(8'h72, 8'h00);
    chk("word", word_out, wexp(0, 0));
    w(8'hAD, 8'h03);
    chk("word", word_out, wexp(0, 0));
    w(8'hAB, 8'h01);
    chk("word", word_out, wexp(1, 0));
    w(8'h06, 8'h0F);
    w(8'h00, 8'h9F);
    chk("frames", frames_per_multiframe, 16);
    chk("test pattern", transport_pattern_enable, 1);
    chk("lane align", lane_align_insert, 1);
    chk("frame align", frame_align_insert, 1);
    chk("ila enable", ila_send_enable, 0);
    chk("word", word_out, wexp(1, 1));
    w(8'hAD, 8'h00);
    w(8'h00, 8'h00);
    chk("frames", frames_per_multiframe, 5);
    chk("word", word_out, wexp(0, 0));
    for (i = 0; i < 8; i++) begin
      w(8'h02, {i[2:0], 5'h00});
      chk("pattern", link_pattern_select, i < 5 ? i : 0);
    end
    w(8'h02, 8'h90);
    chk("disparity", pattern_disparity_flip, 1);
    w(8'h02, 8'h70);
    chk("disparity", pattern_disparity_flip, 0);
    for (i = 0; i < 10; i++) begin
      w(8'h01, {2'b00, lt[i][9:4]});
      chk("lanes", active_lanes, lt[i][3:0]);
      chk("filter", link_filter_config, lt[i][9:7]);
    end
    w(8'h01, 8'h01);
    alc_rx_model_inst.set_sync(1);
    repeat (4) @(posedge clk);
    #1;
    chk("sync", sync_request, 1);
    w(8'h01, 8'h41);
    chk("sync", sync_request, 0);
    chk("k28.5", k28_5_force, 0);
    w(8'h01, 8'hC1);
    chk("k28.5", k28_5_force, 1);
    chk("sync", sync_request, 1);
    w(8'h01, 8'h01);
    alc_rx_model_inst.set_sync(0);
    n0 = lmfc_seen;
    alc_rx_model_inst.pulse_lmfc();
    repeat (3) @(posedge clk);
    chk("lmfc pulses", lmfc_seen - n0, 1);
    w(8'h02, 8'h08);
    alc_rx_model_inst.pulse_lmfc();
    repeat (3) @(posedge clk);
    chk("lmfc pulses", lmfc_seen - n0, 1);
    n0 = rst_seen;
    w(8'hF7, 8'h01);
    repeat (3) @(posedge clk);
    chk("reset pulses", rst_seen - n0, 1);
    rchk(8'hF7, 32'h0);
    rchk(8'h44, 32'h7F);
    chk("zone", nyquist_zone_onehot, 3'h4);
    rd(12'h080, d, r);
    chk("unmapped resp", r, 2'h2);
    chk("unmapped data", d, 0);
    wr(12'h001, 8'hFF, r);
    chk("misaligned resp", r, 2'h2);
    close_out;
  end
endmodule // tb_top

// ==== verilog/alc_link_config.v ====
// link configuration register bank with output-word shaping and link controls
`include "alc_regs.vh"

module alc_link_config #(
  parameter ADDR_W = 12,
  parameter SMP_W  = 14,
  parameter NCH    = 2
) (
  // clock, reset, enable
  input  wire                 clk,
  input  wire                 srst,
  input  wire                 ce,
  // axi4-lite write address
  input  wire [ADDR_W-1:0]    s_axi_awaddr,
  input  wire                 s_axi_awvalid,
  output reg                  s_axi_awready,
  // axi4-lite write data
  input  wire [31:0]          s_axi_wdata,
  input  wire [3:0]           s_axi_wstrb,
  input  wire                 s_axi_wvalid,
  output reg                  s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]           s_axi_bresp,
  output reg                  s_axi_bvalid,
  input  wire                 s_axi_bready,
  // axi4-lite read address
  input  wire [ADDR_W-1:0]    s_axi_araddr,
  input  wire                 s_axi_arvalid,
  output reg                  s_axi_arready,
  // axi4-lite read data
  output reg  [31:0]          s_axi_rdata,
  output reg  [1:0]           s_axi_rresp,
  output reg                  s_axi_rvalid,
  input  wire                 s_axi_rready,
  // sample path
  input  wire [NCH*SMP_W-1:0] sample_in,
  input  wire [NCH-1:0]       fast_overrange_flag,
  output reg  [NCH*16-1:0]    word_out,
  // link side
  input  wire                 sync_req_n_pin,
  input  wire                 lmfc_reset_req,
  output reg                  lmfc_reset_out,
  output reg                  sync_request,
  output reg                  k28_5_force,
  output reg                  ila_send_enable,
  output reg                  lane_align_insert,
  output reg                  frame_align_insert,
  output reg                  transport_pattern_enable,
  output reg  [5:0]           frames_per_multiframe,
  output reg  [2:0]           link_pattern_select,
  output reg                  pattern_disparity_flip,
  output reg  [3:0]           active_lanes,
  output reg  [2:0]           link_filter_config,
  output reg  [2:0]           link_lane_mode,
  // digital controls
  output reg                  digital_core_reset,
  output reg  [2:0]           nyquist_zone_onehot,
  output reg  [6:0]           gain_value,
  output reg                  gain_active,
  output reg                  lane_remap_active
);

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  reg  [7:0]        link_a_r;
  reg  [7:0]        link_b_r;
  reg  [7:0]        link_test_r;
  reg  [7:0]        frames_r;
  reg  [7:0]        zone_r;
  reg  [7:0]        gain_r;
  reg  [7:0]        nyq_r;
  reg  [7:0]        gain_rmp_r;
  reg  [7:0]        rmp2_r;
  reg  [7:0]        lsb_en_r;
  reg  [7:0]        lsb_sel_r;
  reg               dig_rst_r;
  reg  [3:0]        lanes_nxt;

  // ----------------------------------------
  // bus slave state
  // ----------------------------------------
  reg               aw_got_r;
  reg               w_got_r;
  reg  [ADDR_W-1:0] aw_addr_r;
  reg  [7:0]        w_data_r;
  reg               w_lane0_r;
  reg  [7:0]        rd_val;
  reg               rd_hit;
  reg               wr_hit;
  reg  [1:0]        sync_pin_r;

  wire              wr_fire;
  wire [7:0]        wr_idx;
  wire [7:0]        rd_idx;
  wire              wr_aligned;
  wire              rd_aligned;
  wire              wr_en;

  assign wr_fire    = aw_got_r & w_got_r & ~s_axi_bvalid;
  assign wr_idx     = aw_addr_r[9:2];
  assign rd_idx     = s_axi_araddr[9:2];
  assign wr_aligned = (aw_addr_r[1:0] == 2'h0) && (aw_addr_r >> 10) == 0;
  assign rd_aligned = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr >> 10) == 0;
  assign wr_en      = wr_fire & wr_hit & wr_aligned & w_lane0_r;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  always @* begin
    case (wr_idx)
      `ALC_IDX_LINK_A, `ALC_IDX_LINK_B, `ALC_IDX_LINK_TEST,
      `ALC_IDX_FRAMES, `ALC_IDX_ZONE, `ALC_IDX_GAIN, `ALC_IDX_NYQ,
      `ALC_IDX_GAIN_RMP, `ALC_IDX_RMP2, `ALC_IDX_LSB_EN,
      `ALC_IDX_LSB_SEL, `ALC_IDX_DIG_RST: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // write-only reset register reads zero
  always @* begin
    rd_hit = 1'b1;
    case (rd_idx)
      `ALC_IDX_LINK_A:    rd_val = link_a_r;
      `ALC_IDX_LINK_B:    rd_val = link_b_r;
      `ALC_IDX_LINK_TEST: rd_val = link_test_r;
      `ALC_IDX_FRAMES:    rd_val = frames_r;
      `ALC_IDX_ZONE:      rd_val = zone_r;
      `ALC_IDX_GAIN:      rd_val = gain_r;
      `ALC_IDX_NYQ:       rd_val = nyq_r;
      `ALC_IDX_GAIN_RMP:  rd_val = gain_rmp_r;
      `ALC_IDX_RMP2:      rd_val = rmp2_r;
      `ALC_IDX_LSB_EN:    rd_val = lsb_en_r;
      `ALC_IDX_LSB_SEL:   rd_val = lsb_sel_r;
      `ALC_IDX_DIG_RST:   rd_val = 8'h00;
      `ALC_IDX_STATUS:    rd_val = {3'h0, sync_request, active_lanes};
      default: begin
        rd_val = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
    if (!rd_aligned) begin
      rd_hit = 1'b0;
      rd_val = 8'h00;
    end
  end

  // ----------------------------------------
  // axi4-lite handshakes
  // ----------------------------------------
  // one write and one read in flight; ready drops until the response is taken
  always @(posedge clk) begin
    if (srst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `ALC_RESP_OKAY;
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      aw_addr_r     <= {ADDR_W{1'b0}};
      w_data_r      <= 8'h00;
      w_lane0_r     <= 1'b0;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `ALC_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awready && s_axi_awvalid) begin
        aw_addr_r     <= s_axi_awaddr;
        aw_got_r      <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wready && s_axi_wvalid) begin
        w_data_r     <= s_axi_wdata[7:0];
        w_lane0_r    <= s_axi_wstrb[0];
        w_got_r      <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_hit && wr_aligned) ? `ALC_RESP_OKAY : `ALC_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_got_r      <= 1'b0;
        w_got_r       <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      if (s_axi_arready && s_axi_arvalid) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {24'h000000, rd_val};
        s_axi_rresp   <= rd_hit ? `ALC_RESP_OKAY : `ALC_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // register file
  // ----------------------------------------
  // reserved bits are masked off, so a stray one written there is dropped
  always @(posedge clk) begin
    if (srst) begin
      link_a_r    <= `ALC_RST_LINK_A;
      link_b_r    <= `ALC_RST_LINK_B;
      link_test_r <= `ALC_RST_LINK_TEST;
      frames_r    <= `ALC_RST_FRAMES;
      zone_r      <= `ALC_RST_ZERO;
      gain_r      <= `ALC_RST_ZERO;
      nyq_r       <= `ALC_RST_ZERO;
      gain_rmp_r  <= `ALC_RST_ZERO;
      rmp2_r      <= `ALC_RST_ZERO;
      lsb_en_r    <= `ALC_RST_ZERO;
      lsb_sel_r   <= `ALC_RST_ZERO;
      dig_rst_r   <= 1'b0;
    end else if (ce) begin
      dig_rst_r <= wr_en && (wr_idx == `ALC_IDX_DIG_RST) && w_data_r[0];
      if (wr_en) begin
        case (wr_idx)
          `ALC_IDX_LINK_A:    link_a_r    <= w_data_r & `ALC_MSK_LINK_A;
          `ALC_IDX_LINK_B:    link_b_r    <= w_data_r & `ALC_MSK_LINK_B;
          `ALC_IDX_LINK_TEST: link_test_r <= w_data_r & `ALC_MSK_LINK_TEST;
          `ALC_IDX_FRAMES:    frames_r    <= w_data_r & `ALC_MSK_FRAMES;
          `ALC_IDX_ZONE:      zone_r      <= w_data_r & `ALC_MSK_ZONE;
          `ALC_IDX_GAIN:      gain_r      <= w_data_r & `ALC_MSK_GAIN;
          `ALC_IDX_NYQ:       nyq_r       <= w_data_r & `ALC_MSK_NYQ;
          `ALC_IDX_GAIN_RMP:  gain_rmp_r  <= w_data_r & `ALC_MSK_GAIN_RMP;
          `ALC_IDX_RMP2:      rmp2_r      <= w_data_r & `ALC_MSK_RMP2;
          `ALC_IDX_LSB_EN:    lsb_en_r    <= w_data_r & `ALC_MSK_LSB_EN;
          `ALC_IDX_LSB_SEL:   lsb_sel_r   <= w_data_r & `ALC_MSK_LSB_SEL;
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // lane count lookup
  // ----------------------------------------
  // unlisted filter/mode pairs give zero lanes rather than a guess
  always @* begin
    case ({link_b_r[5:3], link_b_r[2:0]})
      6'h04: lanes_nxt = 4'h4;
      6'h02: lanes_nxt = 4'h4;
      6'h01: lanes_nxt = 4'h8;
      6'h39: lanes_nxt = 4'h4;
      6'h31: lanes_nxt = 4'h4;
      6'h32: lanes_nxt = 4'h2;
      6'h21: lanes_nxt = 4'h2;
      6'h3A: lanes_nxt = 4'h2;
      6'h22: lanes_nxt = 4'h1;
      default: lanes_nxt = 4'h0;
    endcase
  end

  // ----------------------------------------
  // sync pin synchroniser
  // ----------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      sync_pin_r <= 2'h3;
    end else if (ce) begin
      sync_pin_r <= {sync_pin_r[0], sync_req_n_pin};
    end
  end

  // ----------------------------------------
  // link and digital controls
  // ----------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      lmfc_reset_out           <= 1'b0;
      sync_request             <= 1'b0;
      k28_5_force              <= 1'b0;
      ila_send_enable          <= 1'b1;
      lane_align_insert        <= 1'b0;
      frame_align_insert       <= 1'b0;
      transport_pattern_enable <= 1'b0;
      frames_per_multiframe    <= `ALC_FRAMES_DEF;
      link_pattern_select      <= 3'h0;
      pattern_disparity_flip   <= 1'b0;
      active_lanes             <= 4'h8;
      link_filter_config       <= 3'h0;
      link_lane_mode           <= 3'h1;
      digital_core_reset       <= 1'b0;
      nyquist_zone_onehot      <= 3'h0;
      gain_value               <= 7'h00;
      gain_active              <= 1'b0;
      lane_remap_active        <= 1'b0;
    end else if (ce) begin
      lmfc_reset_out <= lmfc_reset_req & ~link_test_r[`ALC_B_LMFC_MSK];
      if (link_b_r[`ALC_B_SYNC_SRC])
        sync_request <= link_b_r[`ALC_B_SYNC_REG];
      else
        sync_request <= ~sync_pin_r[1];
      k28_5_force <= link_b_r[`ALC_B_SYNC_REG] & link_b_r[`ALC_B_SYNC_SRC];
      ila_send_enable          <= ~link_a_r[`ALC_B_ILA_DIS];
      lane_align_insert        <= link_a_r[`ALC_B_LANE_AL];
      frame_align_insert       <= link_a_r[`ALC_B_FRAME_AL];
      transport_pattern_enable <= link_a_r[`ALC_B_TPAT];
      if (link_a_r[`ALC_B_OVR_K])
        frames_per_multiframe <= {1'b0, frames_r[4:0]} + 6'h01;
      else
        frames_per_multiframe <= `ALC_FRAMES_DEF;
      // unused pattern codes fall back to normal data
      if (link_test_r[7:5] <= `ALC_PAT_RPAT)
        link_pattern_select <= link_test_r[7:5];
      else
        link_pattern_select <= 3'h0;
      pattern_disparity_flip <= link_test_r[`ALC_B_DISP] &&
                                (link_test_r[7:5] == `ALC_PAT_RPAT);
      active_lanes       <= lanes_nxt;
      link_filter_config <= link_b_r[5:3];
      link_lane_mode     <= link_b_r[2:0];
      digital_core_reset <= dig_rst_r;
      // zone logic belongs to interleaving correction, kept out of the digital reset
      if (nyq_r[7]) begin
        case (zone_r[2:0])
          3'h0: nyquist_zone_onehot <= 3'h1;
          3'h1: nyquist_zone_onehot <= 3'h2;
          3'h2: nyquist_zone_onehot <= 3'h4;
          default: nyquist_zone_onehot <= 3'h0;
        endcase
      end else begin
        nyquist_zone_onehot <= 3'h0;
      end
      gain_active <= gain_rmp_r[0];
      gain_value  <= gain_rmp_r[0] ? gain_r[6:0] : 7'h00;
      // the device trusts software to set these only in down-converter mode
      lane_remap_active <= gain_rmp_r[7] & rmp2_r[3];
    end
  end

  // ----------------------------------------
  // output word shaping per channel
  // ----------------------------------------
  wire lsb_sub;
  assign lsb_sub = lsb_en_r[0] && (lsb_sel_r[1:0] == `ALC_LSB_SEL_OVR);

  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch = ch + 1) begin : g_ch
      reg [15:0] word_nxt;
      reg [15:0] word_pre;
      integer    b;
      // reversal reads a separate word; swapping in place would mirror half the bits
      always @* begin
        word_pre = {sample_in[ch*SMP_W +: SMP_W], 2'h0};
        if (lsb_sub)
          word_pre[0] = fast_overrange_flag[ch];
        for (b = 0; b < 16; b = b + 1)
          word_nxt[b] = link_a_r[`ALC_B_FLIP] ? word_pre[15-b] : word_pre[b];
      end
      // the digital reset clears the data path for one cycle
      always @(posedge clk) begin
        if (srst) begin
          word_out[ch*16 +: 16] <= 16'h0000;
        end else if (ce) begin
          if (dig_rst_r)
            word_out[ch*16 +: 16] <= 16'h0000;
          else
            word_out[ch*16 +: 16] <= word_nxt;
        end
      end
    end
  endgenerate

endmodule // alc_link_config

// ==== verilog/alc_regs.vh ====
// register indices, field masks, reset values and codes for the link config bank
`ifndef ALC_REGS_VH
`define ALC_REGS_VH
// register indices, byte address is four times the index
`define ALC_IDX_LINK_A     8'h00
`define ALC_IDX_LINK_B     8'h01
`define ALC_IDX_LINK_TEST  8'h02
`define ALC_IDX_FRAMES     8'h06
`define ALC_IDX_STATUS     8'h10
`define ALC_IDX_ZONE       8'h42
`define ALC_IDX_GAIN       8'h44
`define ALC_IDX_NYQ        8'h4E
`define ALC_IDX_GAIN_RMP   8'h52
`define ALC_IDX_RMP2       8'h72
`define ALC_IDX_LSB_EN     8'hAB
`define ALC_IDX_LSB_SEL    8'hAD
`define ALC_IDX_DIG_RST    8'hF7
// writable bit masks, reserved bits read zero
`define ALC_MSK_LINK_A     8'h9F
`define ALC_MSK_LINK_B     8'hFF
`define ALC_MSK_LINK_TEST  8'hF8
`define ALC_MSK_FRAMES     8'h1F
`define ALC_MSK_ZONE       8'h07
`define ALC_MSK_GAIN       8'h7F
`define ALC_MSK_NYQ        8'h80
`define ALC_MSK_GAIN_RMP   8'h81
`define ALC_MSK_RMP2       8'h08
`define ALC_MSK_LSB_EN     8'h01
`define ALC_MSK_LSB_SEL    8'h03
// reset values
`define ALC_RST_LINK_A     8'h00
`define ALC_RST_LINK_B     8'h01
`define ALC_RST_LINK_TEST  8'h00
`define ALC_RST_FRAMES     8'h08
`define ALC_RST_ZERO       8'h00
// field positions
`define ALC_B_OVR_K        7
`define ALC_B_TPAT         4
`define ALC_B_FLIP         3
`define ALC_B_LANE_AL      2
`define ALC_B_FRAME_AL     1
`define ALC_B_ILA_DIS      0
`define ALC_B_SYNC_REG     7
`define ALC_B_SYNC_SRC     6
`define ALC_B_LMFC_MSK     3
`define ALC_B_DISP         4
// codes
`define ALC_FRAMES_DEF     6'h05
`define ALC_LSB_SEL_OVR    2'h3
`define ALC_PAT_RPAT       3'h4
`define ALC_RESP_OKAY      2'h0
`define ALC_RESP_SLVERR    2'h2
`endif
